// ---- alu_map.vh ----
`ifndef ALU_MAP_VH
`define ALU_MAP_VH
// major opcodes
`define OP_REG_GROUP 6'h00
`define OP_BRANCH_EQ 6'h04
`define OP_SUM_IMM_TRAP 6'h08
`define OP_SUM_IMM_WRAP 6'h09
`define OP_MASK_IMM 6'h0c
// function codes of the register format group
`define FN_SUM_WORD_WRAP 6'h21
`define FN_MASK_WORD 6'h24
// instruction field positions
`define F_OP_HI 31
`define F_OP_LO 26
`define F_SA_HI 25
`define F_SA_LO 21
`define F_SB_HI 20
`define F_SB_LO 16
`define F_DR_HI 15
`define F_DR_LO 11
`define F_SH_HI 10
`define F_SH_LO 6
`define F_FN_HI 5
`define F_FN_LO 0
`define F_IMM_HI 15
`define F_IMM_LO 0
`define F_IMM_SIGN 15
// constants
`define REG_ZERO 5'h00
`define SHAMT_ZERO 5'h00
`define WORD_ZERO 32'h00000000
`define HALF_ZERO 16'h0000
`define INSTR_BYTES 32'h00000004
`define REG_RESET 5'h00
`endif

// ---- result_hold.v ----
// registered result stage for the register write port
module result_hold (
  input wire clk_i,
  input wire reset_i,
  input wire wr_en_i,
  input wire [4:0] wr_idx_i,
  input wire [31:0] wr_data_i,
  output reg wr_en_o,
  output reg [4:0] wr_idx_o,
  output reg [31:0] wr_data_o
);
`include "alu_map.vh"

  // hold the write request one cycle
  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_en_o <= 1'h0;
      wr_idx_o <= `REG_RESET;
      wr_data_o <= `WORD_ZERO;
    end else begin
      wr_en_o <= wr_en_i;
      wr_idx_o <= wr_idx_i;
      wr_data_o <= wr_data_i;
    end
  end
endmodule

// ---- integer_add_logic_unit.v ----
// Functional notes
// - opcode 001000 is trapping immediate add
// - sign-extend immediate, add to source
// - overflow when sum bits 32, 31 differ
// - no overflow: write sum to bits 20..16
// - opcode 001001 wrapping immediate add, write
// - wrapping adds never raise overflow
// - function 100001 with shamt zero: wrapping add
// - function 100100: register AND to bits 15..11
// - opcode 001100: zero-extended immediate AND
// - branch-equal on zero registers always taken
// - target is delay-slot address plus offset
module integer_add_logic_unit (
  input wire clk_i,
  input wire reset_i,
  input wire issue_i,
  input wire [31:0] instr_i,
  input wire [31:0] instr_addr_i,
  input wire [31:0] source_a_i,
  input wire [31:0] source_b_i,
  output wire [4:0] source_a_index_o,
  output wire [4:0] source_b_or_dest_index_o,
  output wire reg_wr_en_o,
  output wire [4:0] reg_wr_idx_o,
  output wire [31:0] reg_wr_data_o,
  output reg overflow_o,
  output reg [31:0] fault_addr_o,
  output reg branch_taken_o,
  output reg [31:0] branch_target_o,
  output reg unknown_instr_o
);
`include "alu_map.vh"

  // instruction fields, sliced straight from the issued word
  wire [5:0] opcode; // major opcode
  wire [4:0] source_a_index; // first source field
  wire [4:0] source_b_or_dest_index; // second source or destination
  wire [4:0] dest_reg_index; // register-format destination
  wire [4:0] shamt; // must be zero for the wrapping register add
  wire [5:0] funct; // function code of the register format group
  wire [15:0] imm; // immediate or branch offset

  assign opcode = instr_i[`F_OP_HI:`F_OP_LO];
  assign source_a_index = instr_i[`F_SA_HI:`F_SA_LO];
  assign source_b_or_dest_index = instr_i[`F_SB_HI:`F_SB_LO];
  assign dest_reg_index = instr_i[`F_DR_HI:`F_DR_LO];
  assign shamt = instr_i[`F_SH_HI:`F_SH_LO];
  assign funct = instr_i[`F_FN_HI:`F_FN_LO];
  assign imm = instr_i[`F_IMM_HI:`F_IMM_LO];

  // register file read indices leave combinationally: the register file
  // answers in the issue cycle, so a flop here would cost a whole stage
  assign source_a_index_o = source_a_index;
  assign source_b_or_dest_index_o = source_b_or_dest_index;

  // decode strobes, each except is_reg_group qualified by issue so that idle cycles decode nothing
  wire is_reg_group; // register format group selected
  wire sum_imm_trapping; // immediate add that traps on overflow
  wire sum_imm_wrapping; // immediate add, modulo
  wire sum_word_wrapping; // register add, modulo
  wire mask_word; // register bitwise and
  wire mask_with_imm; // bitwise and with zero-extended immediate
  wire branch_if_equal; // branch-equal on register zero only
  wire decoded_any; // some form above claimed the word

  assign is_reg_group = (opcode == `OP_REG_GROUP);
  assign sum_imm_trapping = issue_i && (opcode == `OP_SUM_IMM_TRAP);
  assign sum_imm_wrapping = issue_i && (opcode == `OP_SUM_IMM_WRAP);
  // a nonzero shift field makes this word something else, so it stays unknown
  assign sum_word_wrapping = issue_i && is_reg_group && (funct == `FN_SUM_WORD_WRAP)
    && (shamt == `SHAMT_ZERO);
  // the and form does not look at the shift field
  assign mask_word = issue_i && is_reg_group && (funct == `FN_MASK_WORD);
  assign mask_with_imm = issue_i && (opcode == `OP_MASK_IMM);
  // only the both-zero register encoding is always taken; other compares are not ours
  assign branch_if_equal = issue_i && (opcode == `OP_BRANCH_EQ)
    && (source_a_index == `REG_ZERO) && (source_b_or_dest_index == `REG_ZERO);
  assign decoded_any = sum_imm_trapping || sum_imm_wrapping || sum_word_wrapping
    || mask_word || mask_with_imm || branch_if_equal;

  // operand shaping
  wire [31:0] imm_sext; // immediate with its sign copied upward
  wire [31:0] imm_zext; // immediate with zeros above
  wire [32:0] sum_trap; // one guard bit above the word
  wire sum_overflow; // guard bit and sign bit disagree
  wire [31:0] sum_imm; // modulo immediate sum
  wire [31:0] sum_reg; // modulo register sum
  wire [31:0] delay_slot_addr; // word after the branch
  wire [31:0] br_offset; // offset in bytes, sign-extended
  wire [31:0] br_target; // redirect address

  assign imm_sext = {{16{imm[`F_IMM_SIGN]}}, imm};
  assign imm_zext = {`HALF_ZERO, imm};
  // the source is widened with a copy of its own sign so that a carry into
  // the guard bit can be told apart from a genuine change of sign
  assign sum_trap = {source_a_i[31], source_a_i} + {imm_sext[31], imm_sext};
  assign sum_overflow = sum_trap[32] != sum_trap[31];
  assign sum_imm = source_a_i + imm_sext;
  assign sum_reg = source_a_i + source_b_i;
  // branch offsets count from the delay slot, not from the branch itself
  assign delay_slot_addr = instr_addr_i + `INSTR_BYTES;
  assign br_offset = {{14{imm[`F_IMM_SIGN]}}, imm, 2'h0};
  assign br_target = delay_slot_addr + br_offset;

  // bitwise and, one slice per bit for both and forms
  wire [31:0] and_reg_bits; // register and register
  wire [31:0] and_imm_bits; // register and immediate
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 32; bit_idx = bit_idx + 1) begin : g_and_bit
      assign and_reg_bits[bit_idx] = source_a_i[bit_idx] & source_b_i[bit_idx];
      assign and_imm_bits[bit_idx] = source_a_i[bit_idx] & imm_zext[bit_idx];
    end
  endgenerate

  // result selection for the write port; idle and unknown words leave it low
  reg wr_en_nxt; // write request for the next cycle
  reg [4:0] wr_idx_nxt; // destination index
  reg [31:0] wr_data_nxt; // value to write
  always @* begin
    wr_en_nxt = 1'h0;
    wr_idx_nxt = `REG_RESET;
    wr_data_nxt = `WORD_ZERO;
    if (sum_imm_trapping) begin
      // write only when the sum fits; index and data still travel
      wr_en_nxt = !sum_overflow;
      wr_idx_nxt = source_b_or_dest_index;
      wr_data_nxt = sum_trap[31:0];
    end else if (sum_imm_wrapping) begin
      // modulo sum, never traps
      wr_en_nxt = 1'h1;
      wr_idx_nxt = source_b_or_dest_index;
      wr_data_nxt = sum_imm;
    end else if (sum_word_wrapping) begin
      // modulo register sum into the third register field
      wr_en_nxt = 1'h1;
      wr_idx_nxt = dest_reg_index;
      wr_data_nxt = sum_reg;
    end else if (mask_word) begin
      // register and, no exception possible
      wr_en_nxt = 1'h1;
      wr_idx_nxt = dest_reg_index;
      wr_data_nxt = and_reg_bits;
    end else if (mask_with_imm) begin
      // immediate and into the second register field
      wr_en_nxt = 1'h1;
      wr_idx_nxt = source_b_or_dest_index;
      wr_data_nxt = and_imm_bits;
    end else begin
      // no write for branches, idle cycles or unknown words
      wr_en_nxt = 1'h0;
    end
  end

  // status next values, all settled in the issue cycle
  reg overflow_nxt; // trapping add overflowed
  reg [31:0] fault_addr_nxt; // address kept for the exception logic
  reg branch_taken_nxt; // unconditional branch seen
  reg [31:0] branch_target_nxt; // address kept for the fetch side
  reg unknown_instr_nxt; // issued word not handled here
  always @* begin
    // hold the recorded addresses unless a new event replaces them
    overflow_nxt = sum_imm_trapping && sum_overflow;
    fault_addr_nxt = fault_addr_o;
    branch_taken_nxt = branch_if_equal;
    branch_target_nxt = branch_target_o;
    unknown_instr_nxt = issue_i && !decoded_any;
    if (overflow_nxt) begin
      // the faulting word's own address, not the next one
      fault_addr_nxt = instr_addr_i;
    end
    if (branch_if_equal) begin
      // fetch applies it after the delay slot word
      branch_target_nxt = br_target;
    end
  end

  // registered write port, valid right after the edge that takes the word
  result_hold u_result_hold (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_en_i(wr_en_nxt),
    .wr_idx_i(wr_idx_nxt),
    .wr_data_i(wr_data_nxt),
    .wr_en_o(reg_wr_en_o),
    .wr_idx_o(reg_wr_idx_o),
    .wr_data_o(reg_wr_data_o)
  );

  // overflow pulse, in the same cycle as the dropped write
  always @(posedge clk_i) begin
    if (reset_i) begin
      overflow_o <= 1'h0;
    end else begin
      overflow_o <= overflow_nxt;
    end
  end

  // fault address, held until the next overflow
  always @(posedge clk_i) begin
    if (reset_i) begin
      fault_addr_o <= `WORD_ZERO;
    end else begin
      fault_addr_o <= fault_addr_nxt;
    end
  end

  // branch pulse for the fetch side
  always @(posedge clk_i) begin
    if (reset_i) begin
      branch_taken_o <= 1'h0;
    end else begin
      branch_taken_o <= branch_taken_nxt;
    end
  end

  // branch target, held until the next branch
  always @(posedge clk_i) begin
    if (reset_i) begin
      branch_target_o <= `WORD_ZERO;
    end else begin
      branch_target_o <= branch_target_nxt;
    end
  end

  // unknown word pulse, so the decoder can raise its own fault
  always @(posedge clk_i) begin
    if (reset_i) begin
      unknown_instr_o <= 1'h0;
    end else begin
      unknown_instr_o <= unknown_instr_nxt;
    end
  end
endmodule

// ---- reg_file_model.sv ----
// register file read side: combinational, same cycle as the index
module reg_file_model (
  input wire logic [4:0] a_idx_i,
  input wire logic [4:0] b_idx_i,
  output logic [31:0] a_val_o,
  output logic [31:0] b_val_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // fixed contents chosen to reach both overflow directions
  function automatic logic [31:0] val(input logic [4:0] i);
    case (i)
      5'h01: val = 32'h7fffffff;
      5'h02: val = 32'h80000000;
      5'h03: val = 32'h0f0f00ff;
      default: val = {27'h0, i};
    endcase
  endfunction
  assign a_val_o = val(a_idx_i);
  assign b_val_o = val(b_idx_i);
endmodule

// ---- integer_add_logic_unit_monitor.sv ----
module alu_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic issue_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] instr_addr_i,
  input wire logic [31:0] source_a_i,
  input wire logic [31:0] source_b_i,
  input wire logic reg_wr_en_o,
  input wire logic [4:0] reg_wr_idx_o,
  input wire logic [31:0] reg_wr_data_o,
  input wire logic overflow_o,
  input wire logic [31:0] fault_addr_o,
  input wire logic branch_taken_o,
  input wire logic [31:0] branch_target_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // expected results worked out from the operands
  wire [31:0] sx = {{16{instr_i[15]}}, instr_i[15:0]};
  wire [32:0] t = {source_a_i[31], source_a_i} + {sx[31], sx};
  wire [31:0] sum = t[31:0];
  wire ov = t[32] != t[31];
  wire [5:0] op = issue_i ? instr_i[31:26] : 6'h3f;
  wire [4:0] rt = instr_i[20:16];
  wire [4:0] rd = instr_i[15:11];
  wire [31:0] ab_sum = source_a_i + source_b_i;
  wire [31:0] ab_and = source_a_i & source_b_i;
  wire [31:0] im_and = source_a_i & {16'h0, instr_i[15:0]};
  wire [31:0] tgt = instr_addr_i + 32'h4 + {{14{instr_i[15]}}, instr_i[15:0], 2'b00};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_trap;
    op == 6'h08;
  endsequence
  a_trap_ovf: assert property (s_trap ##0 ov |=> overflow_o && !reg_wr_en_o
    && fault_addr_o == $past(instr_addr_i))
    else $error("trap overflow wrong");
  a_trap_sum: assert property (s_trap ##0 !ov |=> reg_wr_en_o && !overflow_o
    && reg_wr_data_o == $past(sum) && reg_wr_idx_o == $past(rt))
    else $error("trap sum wrong");
  a_wrap_imm: assert property (op == 6'h09 |=> reg_wr_en_o && !overflow_o
    && reg_wr_data_o == $past(sum) && reg_wr_idx_o == $past(rt))
    else $error("wrap imm wrong");
  a_wrap_reg: assert property (op == 6'h00 && instr_i[10:0] == 11'h021 |=> reg_wr_en_o && !overflow_o
    && reg_wr_data_o == $past(ab_sum) && reg_wr_idx_o == $past(rd))
    else $error("wrap reg wrong");
  a_and_reg: assert property (op == 6'h00 && instr_i[5:0] == 6'h24 |=> reg_wr_en_o && !overflow_o
    && reg_wr_data_o == $past(ab_and) && reg_wr_idx_o == $past(rd))
    else $error("and reg wrong");
  a_and_imm: assert property (op == 6'h0c |=> reg_wr_en_o && !overflow_o
    && reg_wr_data_o == $past(im_and) && reg_wr_idx_o == $past(rt))
    else $error("and imm wrong");
  a_branch_tgt: assert property (op == 6'h04 && instr_i[25:16] == 10'h0 |=> branch_taken_o
    && !reg_wr_en_o && branch_target_o == $past(tgt))
    else $error("branch wrong");
  a_ovf_cause: assert property (overflow_o |-> $past(op) == 6'h08 && $past(ov))
    else $error("stray overflow");
endmodule
bind integer_add_logic_unit alu_monitor u_mon (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .issue_i(issue_i),
  .instr_i(instr_i),
  .instr_addr_i(instr_addr_i),
  .source_a_i(source_a_i),
  .source_b_i(source_b_i),
  .reg_wr_en_o(reg_wr_en_o),
  .reg_wr_idx_o(reg_wr_idx_o),
  .reg_wr_data_o(reg_wr_data_o),
  .overflow_o(overflow_o),
  .fault_addr_o(fault_addr_o),
  .branch_taken_o(branch_taken_o),
  .branch_target_o(branch_target_o)
);

// ---- integer_add_logic_unit_tb.sv ----
module integer_add_logic_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, reset_i = 1, issue_i = 0;
  logic [31:0] instr_i = 0, instr_addr_i = 0, source_a_i, source_b_i, fault_addr_o, branch_target_o, reg_wr_data_o;
  logic [4:0] ia, ib, reg_wr_idx_o;
  logic reg_wr_en_o, overflow_o, branch_taken_o, unknown_instr_o;
  int num_errors = 0, total_checks = 0, cyc = 0;
  // rows: word, then {write, overflow, branch, unknown}, then {index, data}
  logic [72:0] rows [9] = '{{32'h20250001, 4'h4, 37'h0}, {32'h2066ffff, 4'h8, 37'h60f0f00fe},
    {32'h20478000, 4'h4, 37'h0}, {32'h24280001, 4'h8, 37'h880000000}, {32'h00214821, 4'h8, 37'h9fffffffe},
    {32'h00615024, 4'h8, 37'ha0f0f00ff}, {32'h304bffff, 4'h8, 37'hb00000000}, {32'h1000fffe, 4'h2, 37'h0},
    {32'h00214861, 4'h1, 37'h0}};
  integer_add_logic_unit uut (.clk_i(clk_i), .reset_i(reset_i), .issue_i(issue_i), .instr_i(instr_i),
    .instr_addr_i(instr_addr_i), .source_a_i(source_a_i), .source_b_i(source_b_i), .source_a_index_o(ia),
    .source_b_or_dest_index_o(ib), .reg_wr_en_o(reg_wr_en_o), .reg_wr_idx_o(reg_wr_idx_o),
    .reg_wr_data_o(reg_wr_data_o), .overflow_o(overflow_o), .fault_addr_o(fault_addr_o),
    .branch_taken_o(branch_taken_o), .branch_target_o(branch_target_o), .unknown_instr_o(unknown_instr_o));
  reg_file_model rf (.a_idx_i(ia), .b_idx_i(ib), .a_val_o(source_a_i), .b_val_o(source_b_i));
  always #10 clk_i = ~clk_i;
  // compare and count
  task check(input logic [40:0] g, input logic [40:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task finish_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 0;
    // back-to-back issue; the branch is followed by a non-transfer word
    for (int i = 0; i <= 9; i++) begin
      @(posedge clk_i);
      issue_i <= i < 9;
      instr_i <= i < 9 ? rows[i][72:41] : 32'h0;
      instr_addr_i <= 32'h1000 + 32'(4 * i);
      #1;
      if (i > 0) check({reg_wr_en_o, overflow_o, branch_taken_o, unknown_instr_o,
        reg_wr_en_o ? {reg_wr_idx_o, reg_wr_data_o} : 37'h0}, rows[i-1][40:0]);
    end
    check({9'h0, fault_addr_o}, {9'h0, 32'h1008});
    check({9'h0, branch_target_o}, {9'h0, 32'h1018});
    // mid-run reset: every registered output returns to zero
    @(posedge clk_i);
    reset_i <= 1;
    @(posedge clk_i);
    #1;
    check({9'h0, fault_addr_o | branch_target_o}, 41'h0);
    check({reg_wr_en_o, overflow_o, branch_taken_o, unknown_instr_o, reg_wr_idx_o, reg_wr_data_o}, 41'h0);
    // release with a wrapping add issued at once; index outputs follow the word
    @(posedge clk_i);
    reset_i <= 0;
    issue_i <= 1;
    instr_i <= rows[3][72:41];
    instr_addr_i <= 32'h2000;
    #1;
    check({31'h0, ia, ib}, {31'h0, 5'h01, 5'h08});
    check({reg_wr_en_o, overflow_o, branch_taken_o, unknown_instr_o, 37'h0}, 41'h0);
    @(posedge clk_i);
    issue_i <= 0;
    #1;
    check({reg_wr_en_o, overflow_o, branch_taken_o, unknown_instr_o, reg_wr_idx_o, reg_wr_data_o},
      rows[3][40:0]);
    check({9'h0, fault_addr_o}, 41'h0);
    finish_test();
  end
endmodule
